// ### hw/asfc_top.sv
// Serial frame control and offset calibration sequencing
//
// Operation
// R1: first frame after power-up runs a calibration, not a conversion
// R2: power-up calibration needs sixteen serial clocks with select low
// R3: data output stays low while calibrating
// R4: host waits settle time after calibration before next sample frame
// R5: short first frame leaves the correction store untouched
// R6: later results are corrected by the stored offset and shifted out
// R7: any frame with thirty-two clocks recalibrates in normal operation
// R8: calibrating frame still delivers its sample in first fourteen clocks
// R9: normal calibration runs from 17th to 32nd falling edge
// R10: output low after 14th edge, high impedance after select rises
// R11: normal frame under thirty-two clocks leaves store untouched
// R12: host limits serial clock rate during calibration frames
// R13: host holds select high at least the settle time between frames
// R14: leading zero at select fall, another zero, then twelve result bits
// R15: sample at select fall, select rise ends frame and releases output
// R16: store clears at power-up and has no serial access path
// R17: results are twelve-bit twos complement, full scale both ways
module asfc_top
    import asfc_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         link_sclk,
    input  wire logic         cs_n,
    output logic              sdo,
    output logic              sdo_oe,
    input  wire asfc_sample_s smp_in,
    input  wire logic         smp_valid,
    output logic              smp_ready,
    input  wire logic [11:0]  offset_meas,
    output logic              cal_done,
    output logic              calibrated,
    output logic              settle_short
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Link side
    logic [5:0]   edge_cnt_ff;
    logic         sdo_ff;
    logic         cal_run_ff;
    logic         reach_pup_ff;
    logic         reach_norm_ff;

    // Select synchroniser
    logic         cs_s1_ff;
    logic         cs_s2_ff;
    logic         cs_s3_ff;
    logic         cs_lvl_ff;

    // Flag synchronisers
    logic         pup_s1_ff;
    logic         pup_s2_ff;
    logic         pup_s3_ff;
    logic         norm_s1_ff;
    logic         norm_s2_ff;
    logic         norm_s3_ff;

    // System side state
    asfc_state_e  state_ff;
    asfc_state_e  nxt_state;
    logic         seen_pup_ff;
    logic         seen_norm_ff;
    logic [11:0]  offset_store_ff;
    logic [11:0]  tx_word_ff;
    logic         hold_full_ff;
    logic [4:0]   settle_cnt_ff;
    logic         calibrated_ff;
    logic         cal_done_ff;
    logic         settle_short_ff;

    // Buffer outlet
    asfc_sample_s buf_data;
    logic         buf_valid;
    logic         hold_load;

    // ------------------------------------------------------------------
    // Link side: edge count and shift path
    // ------------------------------------------------------------------
    // Count of falling edges including this one, saturating
    wire logic [5:0] nxt_edge_cnt =
        (edge_cnt_ff == EDGE_MAX) ? edge_cnt_ff : edge_cnt_ff + 6'h01;

    // Bit slot of the result for the coming edge
    wire logic       in_data_slot =
        (nxt_edge_cnt >= FIRST_DATA_EDGE) &&
        (nxt_edge_cnt <= LAST_DATA_EDGE);
    wire logic [5:0] slot_idx_full = LAST_DATA_EDGE - nxt_edge_cnt;
    wire logic [3:0] slot_idx      = slot_idx_full[3:0];

    // Word is held still by the system side for the whole frame
    wire logic nxt_sdo = in_data_slot ? tx_word_ff[slot_idx] : 1'b0; // R14

    // Calibration window markers
    wire logic hit_pup   = (nxt_edge_cnt == PUP_CAL_EDGES);
    wire logic hit_start = (nxt_edge_cnt == CAL_START_EDGE);
    wire logic hit_norm  = (nxt_edge_cnt == NORM_CAL_EDGES);

    // Select high clears the frame; edges only run inside a frame
    // Clear is asynchronous, the link clock stands still between frames
    always_ff @(negedge link_sclk or posedge cs_n) begin
        if (cs_n) begin
            edge_cnt_ff   <= 6'h00;
            sdo_ff        <= 1'b0;              // R14
            cal_run_ff    <= 1'b0;
            reach_pup_ff  <= 1'b0;
            reach_norm_ff <= 1'b0;
        end else begin
            edge_cnt_ff <= nxt_edge_cnt;
            sdo_ff      <= nxt_sdo;             // R10
            if (hit_pup) begin
                reach_pup_ff <= 1'b1;           // R2
            end
            if (hit_start) begin
                cal_run_ff <= 1'b1;             // R9
            end
            if (hit_norm && cal_run_ff) begin
                cal_run_ff    <= 1'b0;
                reach_norm_ff <= 1'b1;          // R9
            end
        end
    end

    // Pin drive: enabled only while select is low
    assign sdo    = sdo_ff;
    assign sdo_oe = !cs_n;                      // R15

    // ------------------------------------------------------------------
    // Crossings into the system clock
    // ------------------------------------------------------------------
    // Select pin: three stages, level moves when stages two and three agree
    // Reset to high, the idle level, so no false frame edge follows reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cs_s1_ff  <= 1'b1;
            cs_s2_ff  <= 1'b1;
            cs_s3_ff  <= 1'b1;
            cs_lvl_ff <= 1'b1;
        end else begin
            cs_s1_ff <= cs_n;
            cs_s2_ff <= cs_s1_ff;
            cs_s3_ff <= cs_s2_ff;
            if (cs_s2_ff == cs_s3_ff) begin
                cs_lvl_ff <= cs_s3_ff;
            end
        end
    end

    // Calibration reach flags: three stages each, like the select pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pup_s1_ff  <= 1'b0;
            pup_s2_ff  <= 1'b0;
            pup_s3_ff  <= 1'b0;
            norm_s1_ff <= 1'b0;
            norm_s2_ff <= 1'b0;
            norm_s3_ff <= 1'b0;
        end else begin
            pup_s1_ff  <= reach_pup_ff;
            pup_s2_ff  <= pup_s1_ff;
            pup_s3_ff  <= pup_s2_ff;
            norm_s1_ff <= reach_norm_ff;
            norm_s2_ff <= norm_s1_ff;
            norm_s3_ff <= norm_s2_ff;
        end
    end

    // A reach flag counts once stages two and three agree
    wire logic pup_ok  = pup_s2_ff && pup_s3_ff;
    wire logic norm_ok = norm_s2_ff && norm_s3_ff;

    // Frame edges as seen by the system side
    wire logic cs_fall = cs_lvl_ff && (cs_s2_ff == cs_s3_ff) && !cs_s3_ff;
    wire logic cs_rise = !cs_lvl_ff && (cs_s2_ff == cs_s3_ff) && cs_s3_ff;

    // Select high in every stage, so no frame can be open at the link
    wire logic cs_quiet = cs_s1_ff && cs_s2_ff && cs_s3_ff && cs_lvl_ff;

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    // State walk: power-up wait, first frame, then normal frames
    // Only reset returns to the power-up wait
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_FIRST_WAIT: begin
                if (cs_fall) begin
                    nxt_state = ST_FIRST_FRAME;     // R1
                end
            end
            ST_FIRST_FRAME: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cs_fall) begin
                    nxt_state = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_FIRST_WAIT;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= ST_FIRST_WAIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Calibration outcome
    // ------------------------------------------------------------------
    // Kind of frame now open
    wire logic in_first = (state_ff == ST_FIRST_FRAME);
    wire logic in_norm  = (state_ff == ST_FRAME);

    // Store updates only when the frame reached its edge count
    wire logic pup_commit  = in_first && cs_rise &&
                             (seen_pup_ff || pup_ok);        // R5
    wire logic norm_commit = in_norm && cs_rise &&
                             (seen_norm_ff || norm_ok);      // R11
    wire logic store_load  = pup_commit || norm_commit;

    // Sticky catch of the reach flags; set wins over frame start clear
    // The flags drop with select, before the system side sees it rise
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seen_pup_ff  <= 1'b0;
            seen_norm_ff <= 1'b0;
        end else if (pup_ok || norm_ok) begin
            seen_pup_ff  <= seen_pup_ff || pup_ok;
            seen_norm_ff <= seen_norm_ff || norm_ok;
        end else if (cs_fall) begin
            seen_pup_ff  <= 1'b0;
            seen_norm_ff <= 1'b0;
        end
    end

    // Correction store: internal only, zero at power-up
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            offset_store_ff <= OFFSET_RST;          // R16
        end else if (store_load) begin
            offset_store_ff <= offset_meas;         // R2 R7
        end
    end

    // Calibration status and completion pulse
    // Pulse marks each store load; flag holds until reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            calibrated_ff <= 1'b0;
            cal_done_ff   <= 1'b0;
        end else begin
            calibrated_ff <= calibrated_ff || store_load;
            cal_done_ff   <= store_load;
        end
    end

    assign calibrated = calibrated_ff;
    assign cal_done   = cal_done_ff;

    // ------------------------------------------------------------------
    // Settle timing between frames
    // ------------------------------------------------------------------
    wire logic settle_done = (settle_cnt_ff == SETTLE_CYC);

    // Counts system cycles since the last frame ended
    // Starts at the end count, so reset does not read as a fresh gap
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settle_cnt_ff <= SETTLE_CYC;
        end else if (cs_rise) begin
            settle_cnt_ff <= SETTLE_RST;
        end else if (!settle_done) begin
            settle_cnt_ff <= settle_cnt_ff + 5'h01;
        end
    end

    // Flags a sample frame that starts before the input settled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settle_short_ff <= 1'b0;
        end else begin
            settle_short_ff <= cs_fall && (state_ff == ST_IDLE) &&
                               !settle_done;        // R4 R13
        end
    end

    assign settle_short = settle_short_ff;

    // ------------------------------------------------------------------
    // Sample path: buffer, correction and frame word
    // ------------------------------------------------------------------
    // Two-entry buffer so a stalled frame loses no sample
    asfc_buf u_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_data   (smp_in),
        .in_valid  (smp_valid),
        .in_ready  (smp_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (hold_load)
    );

    // Refill only early in the gap, so the word is still at frame start
    // Link reads the word unsynchronised, so it moves only while
    // every select stage still shows the gap
    assign hold_load = (state_ff == ST_IDLE) && cs_quiet &&
                       !hold_full_ff && !settle_done && buf_valid;

    // Offset-corrected, clamped twos complement code
    wire logic [11:0] corr_code =
        asfc_correct(buf_data.code, offset_store_ff);   // R6 R17

    // Frame word: zero in the first frame, corrected sample later
    // Cleared at frame end, so a frame without a sample sends zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_word_ff   <= SLOT_ZERO[11:0];          // R3
            hold_full_ff <= 1'b0;
        end else if (cs_rise) begin
            tx_word_ff   <= SLOT_ZERO[11:0];
            hold_full_ff <= 1'b0;                   // R15
        end else if (hold_load) begin
            tx_word_ff   <= corr_code;              // R6 R8
            hold_full_ff <= 1'b1;
        end
    end

endmodule // asfc_top

// ### inc/asfc_pkg.sv
// Shared constants, types and helpers for the serial frame and offset block
package asfc_pkg;

    // ------------------------------------------------------------------
    // Result format
    // ------------------------------------------------------------------
    localparam int          RES_W      = 12;
    localparam logic [11:0] CODE_MAX   = 12'h7ff;  // Positive full scale
    localparam logic [11:0] CODE_MIN   = 12'h800;  // Negative full scale
    localparam logic [11:0] OFFSET_RST = 12'h000;  // Store value at power-up
    localparam logic [13:0] SLOT_ZERO  = 14'h0000;

    // ------------------------------------------------------------------
    // Frame timing in serial clock falling edges
    // ------------------------------------------------------------------
    localparam int          EDGE_W          = 6;
    localparam logic [5:0]  EDGE_MAX        = 6'h3f;
    localparam logic [5:0]  FIRST_DATA_EDGE = 6'h02;
    localparam logic [5:0]  LAST_DATA_EDGE  = 6'h0d;
    localparam logic [5:0]  PUP_CAL_EDGES   = 6'h10;  // 16 edges
    localparam logic [5:0]  CAL_START_EDGE  = 6'h11;  // 17th edge
    localparam logic [5:0]  NORM_CAL_EDGES  = 6'h20;  // 32nd edge

    // ------------------------------------------------------------------
    // Host side timing, converted to system clock cycles
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 8000;            // 125 MHz
    localparam int SETTLE_TIME_NS  = 200;             // Sample settle time
    localparam int SETTLE_CYC_INT  =
        (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SETTLE_W   = 5;
    localparam logic [4:0]  SETTLE_CYC = SETTLE_CYC_INT[4:0];
    localparam logic [4:0]  SETTLE_RST = 5'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [11:0] code;
    } asfc_sample_s;

    typedef enum {
        ST_FIRST_WAIT,
        ST_FIRST_FRAME,
        ST_IDLE,
        ST_FRAME
    } asfc_state_e;

    // Subtract offset from raw code, clamp to full scale
    function automatic logic [11:0] asfc_correct(
        input logic [11:0] raw,
        input logic [11:0] ofs
    );
        logic signed [12:0] diff;
        diff = $signed({raw[11], raw}) - $signed({ofs[11], ofs});
        if (diff > 13'sh07ff) begin
            return CODE_MAX;
        end else if (diff < -13'sh0800) begin
            return CODE_MIN;
        end
        return diff[11:0];
    endfunction

endpackage

// ### hw/asfc_buf.sv
// Two-entry sample buffer with valid and ready on both sides
module asfc_buf
    import asfc_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire asfc_sample_s in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output asfc_sample_s      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    asfc_sample_s mem_ff [2];
    logic         wr_ptr_ff;
    logic         rd_ptr_ff;
    logic [1:0]   fill_ff;

    // Handshake decode
    wire logic push = in_valid && in_ready;
    wire logic pop  = out_valid && out_ready;

    assign in_ready  = (fill_ff != 2'h2);
    assign out_valid = (fill_ff != 2'h0);
    assign out_data  = mem_ff[rd_ptr_ff];

    // Entry writes
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            fill_ff   <= 2'h0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff ^ push;
            rd_ptr_ff <= rd_ptr_ff ^ pop;
            fill_ff   <= fill_ff + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // asfc_buf

// ### verif/asfc_checker.sv
// Assertion checker for the serial frame and offset block
module asfc_checker
    import asfc_pkg::*;
(
    input wire logic         clock,
    input wire logic         rst_n,
    input wire logic         link_sclk,
    input wire logic         cs_n,
    input wire logic         sdo,
    input wire logic         sdo_oe,
    input wire asfc_sample_s smp_in,
    input wire logic         smp_valid,
    input wire logic         smp_ready,
    input wire logic [11:0]  offset_meas,
    input wire logic         cal_done,
    input wire logic         calibrated,
    input wire logic         settle_short
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [5:0] edge_ff;
    logic       low_ff;
    logic       seen_ff;

    // Falling serial edges within the current frame
    always_ff @(negedge link_sclk or posedge cs_n) begin
        if (cs_n)
            edge_ff <= 6'h00;
        else if (edge_ff != EDGE_MAX)
            edge_ff <= edge_ff + 6'h01;
    end

    // Notes that the first frame after reset has ended
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_ff  <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            low_ff  <= low_ff | !cs_n;
            seen_ff <= seen_ff | (low_ff & cs_n);
        end
    end

    // ----------
    // Assertions
    // ----------
    a_oe_follows_select: assert property (
        @(posedge clock) disable iff (!rst_n) sdo_oe == !cs_n)
        else $error("output enable does not follow select");
    a_done_sets_flag: assert property (
        @(posedge clock) disable iff (!rst_n) cal_done |=> calibrated)
        else $error("calibrated flag missing after store load");
    a_done_one_cycle: assert property (
        @(posedge clock) disable iff (!rst_n) cal_done |=> !cal_done)
        else $error("calibration pulse longer than one cycle");
    a_done_after_end: assert property (
        @(posedge clock) disable iff (!rst_n)
        cal_done |-> cs_n && $past(cs_n, 3))
        else $error("store loaded before the frame ended");
    a_flag_sticky: assert property (
        @(posedge clock) disable iff (!rst_n) calibrated |=> calibrated)
        else $error("calibrated flag dropped");
    a_first_frame_low: assert property (
        @(posedge link_sclk) disable iff (cs_n) !seen_ff |-> !sdo)
        else $error("data driven during calibration frame");
    a_lead_zero: assert property (
        @(posedge link_sclk) disable iff (cs_n) edge_ff == 6'h01 |-> !sdo)
        else $error("second leading slot not zero");
    a_tail_low: assert property (
        @(posedge link_sclk) disable iff (cs_n) edge_ff >= 6'h0e |-> !sdo)
        else $error("data not low after last result slot");

    // Main scenarios reached
    c_cal_done: cover property (@(posedge clock) cal_done);
    c_calib: cover property (@(posedge clock) $rose(calibrated));
    c_long: cover property (@(posedge link_sclk) edge_ff == 6'h20);

endmodule // asfc_checker

bind asfc_top asfc_checker CHK (
    .clock        (clock),
    .rst_n        (rst_n),
    .link_sclk    (link_sclk),
    .cs_n         (cs_n),
    .sdo          (sdo),
    .sdo_oe       (sdo_oe),
    .smp_in       (smp_in),
    .smp_valid    (smp_valid),
    .smp_ready    (smp_ready),
    .offset_meas  (offset_meas),
    .cal_done     (cal_done),
    .calibrated   (calibrated),
    .settle_short (settle_short)
);

// ### verif/asfc_host.sv
// Host model driving select and serial clock, capturing data
module asfc_host (
    output logic      cs_n,
    output logic      link_sclk,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [14:0] word;
    logic        last;
    logic        line;
    event        done;

    // Released line shows the inverse of its last value
    assign line = sdo_oe ? sdo : !last;

    // Clock stands high and select deasserted between frames
    initial begin
        cs_n = 1'b1;
        link_sclk = 1'b1;
        last = 1'b0;
        word = 15'h0000;
    end

    // -----------
    // Frame drive
    // -----------
    // Slots msb first in word[13:0], bit 14 holds any high tail slot
    task automatic run(input int n);
        int half;
        half = (n >= 16) ? 32 : 15;
        word = 15'h0000;
        cs_n = 1'b0;
        #(half);
        word[13] = line;
        for (int k = 1; k <= n; k++) begin
            link_sclk = 1'b0;
            #(half);
            link_sclk = 1'b1;
            if (k < 14)
                word[13 - k] = line;
            else
                word[14] = word[14] | line;
            last = line;
            #(half);
        end
        #($urandom_range(60, 20));
        cs_n = 1'b1;
        -> done;
    endtask

endmodule // asfc_host

// ### verif/asfc_top_bench.sv
// Self-checking bench for the serial frame and offset block
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module asfc_top_bench
    import asfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic         clock = 1'b0;
    logic         rst_n, cs_n, link_sclk, sdo, sdo_oe;
    asfc_sample_s smp_in;
    logic         smp_valid, smp_ready, cal_done, calibrated, settle_short;
    logic [11:0]  offset_meas, ofs, ofs2, s1, s2;
    logic [14:0]  exp_q[$];
    int           n_tests = 0, n_fail = 0, n_cal = 0, n_settle = 0;

    // System clock
    always #4 clock = ~clock;

    asfc_top DUT (
        .clock        (clock),
        .rst_n        (rst_n),
        .link_sclk    (link_sclk),
        .cs_n         (cs_n),
        .sdo          (sdo),
        .sdo_oe       (sdo_oe),
        .smp_in       (smp_in),
        .smp_valid    (smp_valid),
        .smp_ready    (smp_ready),
        .offset_meas  (offset_meas),
        .cal_done     (cal_done),
        .calibrated   (calibrated),
        .settle_short (settle_short)
    );

    asfc_host HOST (
        .cs_n      (cs_n),
        .link_sclk (link_sclk),
        .sdo       (sdo),
        .sdo_oe    (sdo_oe)
    );

    // Counts calibration and settle pulses away from the edge
    always @(negedge clock) begin
        n_cal    += (cal_done === 1'b1);
        n_settle += (settle_short === 1'b1);
    end

    // Compares each captured frame with the oldest note
    always @(HOST.done) begin : cmp_frame
        logic [14:0] exp_word;
        exp_word = exp_q.pop_front();
        `CHK(HOST.word, exp_word)
    end

    // -----
    // Tasks
    // -----
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic do_reset;
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
    endtask

    task automatic push(input logic [11:0] v);
        logic r;
        @(posedge clock);
        smp_valid   <= 1'b1;
        smp_in.code <= v;
        do begin
            @(negedge clock);
            r = smp_ready;
            @(posedge clock);
        end while (r !== 1'b1);
        smp_valid <= 1'b0;
    endtask

    task automatic frame(input int n, input logic [14:0] e);
        exp_q.push_back(e);
        HOST.run(n);
        repeat (60) @(posedge clock);
    endtask

    // Offset removal with saturation at both full-scale codes
    function automatic logic [14:0] corr(logic [11:0] r, logic [11:0] o);
        int d;
        d = $signed(r) - $signed(o);
        if (d > 2047)
            d = 2047;
        if (d < -2048)
            d = -2048;
        return {3'b000, d[11:0]};
    endfunction

    // ---------
    // Sequence
    // ---------
    initial begin
        rst_n = 1'b0;
        smp_valid = 1'b0;
        smp_in = '0;
        offset_meas = 12'h000;
        void'($urandom(19686));
        ofs  = 12'($urandom_range(12'h7ff, 12'h001));
        ofs2 = 12'($urandom_range(12'h7ff, 12'h001));
        s1   = 12'($urandom());
        s2   = 12'($urandom());
        do_reset();
        offset_meas <= ofs;
        push(s1);
        frame(8, 15'h0000);
        frame(14, corr(s1, 12'h000));
        `CHK(n_cal, 0)
        `CHK(calibrated, 1'b0)
        $display("test short_first done");
        do_reset();
        frame(16, 15'h0000);
        `CHK(n_cal, 1)
        `CHK(calibrated, 1'b1)
        push(s1);
        push(s2);
        @(negedge clock);
        `CHK(smp_ready, 1'b0)
        frame(14, 15'h0000);
        offset_meas <= ofs2;
        frame(20, corr(s1, ofs));
        `CHK(n_cal, 1)
        frame(32, corr(s2, ofs));
        `CHK(n_cal, 2)
        $display("test normal_cal done");
        s1 = 12'($urandom());
        push(12'h800);
        push(s1);
        frame(14, 15'h0000);
        frame(14, corr(12'h800, ofs2));
        frame(14, corr(s1, ofs2));
        `CHK(n_settle, 0)
        $display("test clamp done");
        exp_q.push_back(15'h0000);
        HOST.run(14);
        repeat (6) @(posedge clock);
        frame(14, 15'h0000);
        `CHK(n_settle, 1)
        $display("test short_gap done");
        stop_test();
    end

    // Cuts a hang short
    initial begin
        #150000;
        n_fail++;
        $display("watchdog expired");
        stop_test();
    end

endmodule // asfc_top_bench
